// >>> logic/cbd_cell_ram.sv
// Purpose: Simple dual-port word store for receive cells
// Assumes: One write and one read port on the core clock
// Notes:   Read data is registered and holds until the next read
`timescale 1ns/1ps
module cbd_cell_ram #(
  parameter int W  = 8,
  parameter int AW = 9
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem_q [2**AW];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Registered read, held so a slow link edge can pick it up later
  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule // cbd_cell_ram

// >>> logic/cbd_phy_side.sv
// Purpose: PHY-side direct status flow control for a multi-port cell bus
// Assumes: Link clocks are sampled by clk; link data captured mid-period
// Notes:   Receive cells come from the user port; transmit words go out
// Functional notes
// RULE1 - Start a receive cell only when one is complete and enable is low.
// RULE2 - ATM side lowers receive enable in answer to cell-available.
// RULE3 - During a transfer, RxClav shows whether another cell follows.
// RULE4 - ATM side releases enable two cycles before the end unless chaining.
// RULE5 - RxClav drops together with RxSOC when no further cell waits.
// RULE6 - Once raised, RxClav stays high until that port's next SOC.
// RULE7 - Reaction to each enable change comes two link cycles later.
// RULE8 - First cell word appears two link cycles after enable falls.
// RULE9 - ATM side drops enable when RxClav is low, waits for it again.
// RULE10 - Transmit address names the port; every code is a valid port.
// RULE11 - Receive address names the source port in multi-port mode.
// RULE12 - Up to four ports, each with its own TxClav and RxClav line.
// RULE13 - TxClav ignored one cycle after SOC, then shows room for one more.
// RULE14 - TxClav held until the edge after the next SOC to that port.
// RULE15 - Address before the transmit enable falls selects the port.
// RULE16 - Back-to-back transmit keeps enable low and marks SOC.
// RULE17 - With no TxClav, ATM side stops after the current cell.
// RULE18 - ATM side selects a receive port only when its RxClav is high.
// RULE19 - Address before receive enable falls picks the source port.
// RULE20 - Enable low in next-to-last cycle chains the next cell at once.
// RULE21 - RxSOC is high only in the first cycle of each cell.
// RULE22 - Parity is odd over the whole data bus.
// RULE23 - Each direction is sampled on its own interface clock.
// RULE24 - Words per cell are counted so cell ends are known exactly.
// RULE25 - Cell-available flags come from buffer state, registered per link.
`timescale 1ns/1ps
module cbd_phy_side #(
  parameter int DATA_W     = cbd_pkg::DATA_W,
  parameter int CELL_WORDS = cbd_pkg::CELL_WORDS,
  parameter int NPORT      = cbd_pkg::NPORT,
  localparam int AW        = (NPORT > 1) ? $clog2(NPORT) : 1,
  localparam int IW        = $clog2(CELL_WORDS)
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              rx_clk,
  input  wire logic              rx_enb_n,
  input  wire logic [AW-1:0]     rx_addr,
  output logic      [DATA_W-1:0] rx_data,
  output logic                   rx_prty,
  output logic                   rx_soc,
  output logic      [NPORT-1:0]  rx_clav,
  input  wire logic              tx_clk,
  input  wire logic              tx_enb_n,
  input  wire logic [AW-1:0]     tx_addr,
  input  wire logic              tx_soc,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              tx_prty,
  output logic      [NPORT-1:0]  tx_clav,
  input  wire logic              urx_valid,
  input  wire logic [AW-1:0]     urx_port,
  input  wire logic [DATA_W-1:0] urx_data,
  output logic                   urx_ready,
  output logic                   utx_valid,
  output logic      [AW-1:0]     utx_port,
  output logic      [DATA_W-1:0] utx_data,
  output logic                   utx_soc,
  input  wire logic [NPORT-1:0]  utx_room,
  output logic                   tx_prty_err,
  output logic                   tx_len_err
);
  localparam int MA = AW + 1 + IW;
  localparam int TXW = 1 + AW + 2 + DATA_W;
  localparam logic [IW-1:0] LAST = IW'(CELL_WORDS - 1);

  // Every port code must be a real port, and a cell must hold at least four words
  if (NPORT < 2 || NPORT > 4 || (NPORT & (NPORT - 1)) != 0 || CELL_WORDS < 4)
  begin : g_bad_cfg
    $error("cbd_phy_side: unsupported NPORT or CELL_WORDS");
  end

  // Complete cells not yet claimed by a transfer
  function automatic logic avail_f(input logic [1:0] cnt, input logic tkn);
    return cnt != {1'b0, tkn};
  endfunction

  // Clock samplers: three stages so edges are found past the first flop
  logic [2:0]       rxc_q, txc_q;
  logic [AW:0]      rxi1_q, rxi2_q;
  logic [TXW-1:0]   txi1_q, txi2_q;
  always_ff @(posedge clk)
  begin
    rxc_q  <= {rxc_q[1:0], rx_clk};
    txc_q  <= {txc_q[1:0], tx_clk};
    rxi1_q <= {rx_enb_n, rx_addr};
    rxi2_q <= rxi1_q;
    txi1_q <= {tx_enb_n, tx_addr, tx_soc, tx_prty, tx_data};
    txi2_q <= txi1_q;
  end
  wire rx_rise = rxc_q[1] & ~rxc_q[2]; // [RULE23]
  wire rx_fall = ~rxc_q[1] & rxc_q[2];
  wire tx_rise = txc_q[1] & ~txc_q[2]; // [RULE23]
  wire tx_fall = ~txc_q[1] & txc_q[2];

  // Capture link inputs mid-period so they are stable at the next rise
  logic              rxe_h_q, txe_h_q, txs_h_q, txp_h_q;
  logic [AW-1:0]     rxa_h_q, txa_h_q;
  logic [DATA_W-1:0] txd_h_q;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rxe_h_q <= cbd_pkg::ENB_RST;
      rxa_h_q <= '0;
      txe_h_q <= cbd_pkg::ENB_RST;
      {txa_h_q, txs_h_q, txp_h_q, txd_h_q} <= '0;
    end
    else
    begin
      if (rx_fall)
      begin
        {rxe_h_q, rxa_h_q} <= rxi2_q;
      end
      if (tx_fall)
      begin
        {txe_h_q, txa_h_q, txs_h_q, txp_h_q, txd_h_q} <= txi2_q;
      end
    end
  end

  // Receive buffer bookkeeping, two cell slots per port
  logic [1:0]        cnt_q [NPORT];
  logic [1:0]        cnt_nx [NPORT];
  logic [NPORT-1:0]  taken_q, wslot_q, rslot_q;
  logic              rxe_prev_q, rd_act_q, out_pend_q, out_first_q;
  logic [AW-1:0]     rxa_prev_q, rd_port_q, out_port_q, wr_port_q;
  logic [IW-1:0]     rd_idx_q, wr_idx_q;
  logic [DATA_W-1:0] mem_rdata;

  // Explicit selection only on the enable's falling edge; else same port
  wire [AW-1:0] sel_port = rxe_prev_q ? rxa_prev_q : rd_port_q; // [RULE19] [RULE20]
  wire start = rx_rise && !rd_act_q && !rxe_h_q
               && avail_f(cnt_q[sel_port], taken_q[sel_port]); // [RULE1]
  wire issue = rx_rise && (start || rd_act_q);
  wire [IW-1:0] iss_idx  = start ? '0 : rd_idx_q;
  wire [AW-1:0] iss_port = start ? sel_port : rd_port_q;
  wire last_iss = issue && !start && (rd_idx_q == LAST); // [RULE24]

  // User write side
  wire          wr_acc  = urx_valid && urx_ready;
  wire [AW-1:0] wp      = (wr_idx_q == '0) ? urx_port : wr_port_q;
  wire          wr_done = wr_acc && (wr_idx_q == LAST);
  wire [IW-1:0] wr_idx_nx = wr_done ? '0 : (wr_acc ? wr_idx_q + 1'b1 : wr_idx_q);

  // Next fill counts: completed writes add, finished reads remove
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      cnt_nx[p] = cnt_q[p] + 2'((wr_done && wp == AW'(p)) ? 1 : 0)
                  - 2'((last_iss && rd_port_q == AW'(p)) ? 1 : 0);
    end
  end

  cbd_cell_ram #(
    .W  (DATA_W),
    .AW (MA)
  ) u_ram (
    .clk     (clk),
    .wr_en   (wr_acc),
    .wr_addr ({wp, wslot_q[wp], wr_idx_q}),
    .wr_data (urx_data),
    .rd_en   (issue),
    .rd_addr ({iss_port, rslot_q[iss_port], iss_idx}),
    .rd_data (mem_rdata)
  );

  // Per-port counts and slot pointers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        cnt_q[p] <= '0;
      end
      taken_q <= '0;
      wslot_q <= '0;
      rslot_q <= '0;
    end
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        cnt_q[p] <= cnt_nx[p];
        if (start && sel_port == AW'(p))
        begin
          taken_q[p] <= 1'b1;
        end
        else if (last_iss && rd_port_q == AW'(p))
        begin
          taken_q[p] <= 1'b0;
          rslot_q[p] <= ~rslot_q[p];
        end
        if (wr_done && wp == AW'(p))
        begin
          wslot_q[p] <= ~wslot_q[p];
        end
      end
    end
  end

  // Writer position; ready looks at the next count, a trade for one idle gap
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_idx_q  <= '0;
      wr_port_q <= '0;
      urx_ready <= 1'b0;
    end
    else
    begin
      wr_idx_q  <= wr_idx_nx;
      if (wr_acc && wr_idx_q == '0)
      begin
        wr_port_q <= urx_port;
      end
      urx_ready <= (wr_idx_nx != '0)
                   || (cnt_nx[urx_port] < 2'(cbd_pkg::CELL_SLOTS));
    end
  end

  // Receive sequencer: issue one word per link edge, output one edge later
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rxe_prev_q  <= cbd_pkg::ENB_RST;
      rxa_prev_q  <= '0;
      rd_act_q    <= 1'b0;
      rd_idx_q    <= '0;
      rd_port_q   <= '0;
      out_pend_q  <= 1'b0;
      out_first_q <= 1'b0;
    end
    else if (rx_rise)
    begin
      rxe_prev_q  <= rxe_h_q;
      rxa_prev_q  <= rxa_h_q;
      out_pend_q  <= issue; // [RULE7]
      out_first_q <= start;
      if (start)
      begin
        rd_act_q  <= 1'b1;
        rd_port_q <= sel_port;
        rd_idx_q  <= IW'(1);
      end
      else if (last_iss)
      begin
        rd_act_q <= 1'b0; // Next edge decides on chaining
      end
      else if (rd_act_q)
      begin
        rd_idx_q <= rd_idx_q + 1'b1;
      end
    end
  end

  // Receive outputs and per-port cell-available lines
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_data    <= '0;
      rx_prty    <= 1'b1;
      rx_soc     <= 1'b0;
      out_port_q <= '0;
      rx_clav    <= {NPORT{cbd_pkg::CLAV_RST}};
    end
    else if (rx_rise)
    begin
      rx_data    <= out_pend_q ? mem_rdata : '0; // [RULE8]
      rx_prty    <= ~^(out_pend_q ? mem_rdata : '0); // [RULE22]
      rx_soc     <= out_pend_q && out_first_q; // [RULE21]
      out_port_q <= rd_port_q;
      for (int p = 0; p < NPORT; p++)
      begin
        rx_clav[p] <= avail_f(cnt_q[p], taken_q[p]); // [RULE3] [RULE5] [RULE6] [RULE12] [RULE25]
      end
    end
  end

  // Transmit path: selection, forwarding, checks and room lines
  logic              txe_prev_q;
  logic [AW-1:0]     txa_prev_q, tsel_q;
  logic [IW-1:0]     tcnt_q;
  logic [NPORT-1:0]  soc_seen_q;
  wire               tx_new  = !txe_h_q && txe_prev_q;
  wire [AW-1:0]      tx_port = tx_new ? txa_prev_q : tsel_q; // [RULE15]
  wire               tx_take = tx_rise && !txe_h_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      txe_prev_q  <= cbd_pkg::ENB_RST;
      txa_prev_q  <= '0;
      tsel_q      <= '0;
      tcnt_q      <= '0;
      utx_valid   <= 1'b0;
      utx_port    <= '0;
      utx_data    <= '0;
      utx_soc     <= 1'b0;
      tx_prty_err <= 1'b0;
      tx_len_err  <= 1'b0;
    end
    else
    begin
      utx_valid   <= tx_take;
      tx_prty_err <= tx_take && !(^{txd_h_q, txp_h_q}); // [RULE22]
      tx_len_err  <= tx_take && (txs_h_q != (tcnt_q == '0)); // [RULE24]
      if (tx_rise)
      begin
        txe_prev_q <= txe_h_q;
        txa_prev_q <= txa_h_q;
      end
      if (tx_take)
      begin
        tsel_q   <= tx_port;
        utx_port <= tx_port;
        utx_data <= txd_h_q;
        utx_soc  <= txs_h_q;
        tcnt_q   <= (txs_h_q ? '0 : tcnt_q) == LAST ? '0 : (txs_h_q ? IW'(1) : tcnt_q + 1'b1);
      end
    end
  end

  // Room lines change only on link edges; a high line never drops before the SOC's next edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_clav    <= {NPORT{cbd_pkg::CLAV_RST}};
      soc_seen_q <= '0;
    end
    else if (tx_rise)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (tx_take && txs_h_q && tx_port == AW'(p))
        begin
          soc_seen_q[p] <= 1'b1; // [RULE14]
        end
        else if (soc_seen_q[p])
        begin
          soc_seen_q[p] <= 1'b0;
          tx_clav[p]    <= utx_room[p]; // [RULE13]
        end
        else if (!tx_clav[p])
        begin
          tx_clav[p] <= utx_room[p]; // [RULE12]
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  for (genvar g = 0; g < NPORT; g++)
  begin : g_port_chk
    property p_clav_drop;
      $fell(rx_clav[g]) |-> rx_soc && (out_port_q == AW'(g));
    endproperty
    a_clav_drop: assert property (p_clav_drop) // [RULE5]
      else $error("RxClav fell without SOC on its port");
    property p_tx_hold;
      $fell(tx_clav[g]) |-> $past(soc_seen_q[g]);
    endproperty
    a_tx_hold: assert property (p_tx_hold) // [RULE14]
      else $error("TxClav dropped before the edge after SOC");
  end

  property p_rx_clav_sync;
    $changed(rx_clav) |-> $past(rx_rise);
  endproperty
  a_rx_clav_sync: assert property (p_rx_clav_sync) // [RULE25]
    else $error("RxClav changed off a receive edge");

  property p_tx_clav_sync;
    $changed(tx_clav) |-> $past(tx_rise);
  endproperty
  a_tx_clav_sync: assert property (p_tx_clav_sync) // [RULE13]
    else $error("TxClav changed off a transmit edge");

  property p_soc_lat;
    $rose(rx_soc) |-> $past(out_first_q) && $past(rx_rise) && $past(out_pend_q);
  endproperty
  a_soc_lat: assert property (p_soc_lat) // [RULE8]
    else $error("RxSOC not one edge after cell start");

  property p_rx_par;
    rx_prty == ~^rx_data;
  endproperty
  a_rx_par: assert property (p_rx_par) // [RULE22]
    else $error("Receive parity is not odd");

  property p_start_ok;
    $rose(rd_act_q) |-> $past(!rxe_h_q) && (cnt_q[rd_port_q] != 2'h0);
  endproperty
  a_start_ok: assert property (p_start_ok) // [RULE1]
    else $error("Receive cell started without cell or enable");

  property p_tx_sel;
    (tx_rise && !txe_h_q && txe_prev_q) |=> utx_valid && (utx_port == $past(txa_prev_q));
  endproperty
  a_tx_sel: assert property (p_tx_sel) // [RULE15]
    else $error("Transmit port not from address before enable");
endmodule // cbd_phy_side

// >>> logic/cbd_pkg.sv
// Purpose: Shared constants for the cell bus PHY-side flow control block
// Assumes: One interface clock per direction, sampled by the core clock
// Notes:   Widths and counts here, except CELL_SLOTS, are defaults for module parameters
package cbd_pkg;
  localparam int   DATA_W     = 8;     // Octet-wide cell bus
  localparam int   CELL_WORDS = 52;    // 52-octet cell format on 8 bits
  localparam int   NPORT      = 4;     // Ports with direct status lines
  localparam int   CELL_SLOTS = 2;     // Receive cells buffered per port
  localparam logic CLAV_RST   = 1'b0;  // Cell-available lines after reset
  localparam logic ENB_RST    = 1'b1;  // Enables read as idle after reset
endpackage

// >>> tb/cbd_atm_model.sv
// Purpose: ATM-side partner that selects receive ports and sends cells
// Assumes: Link inputs move just after a link clock rise, held a cycle
// Notes:   lat counts link edges from enable fall to the first SOC seen
`timescale 1ns/1ps
module cbd_atm_model #(
  parameter int CW = 4
) (
  input  wire logic       clk,
  input  wire logic       rx_clk,
  input  wire logic       tx_clk,
  input  wire logic       rx_soc,
  input  wire logic [3:0] rx_clav,
  output logic            rx_enb_n,
  output logic      [1:0] rx_addr,
  output logic            tx_enb_n,
  output logic      [1:0] tx_addr,
  output logic            tx_soc,
  output logic      [7:0] tx_data,
  output logic            tx_prty,
  output logic            hang,
  output logic      [7:0] lat
);
  // Idle link: enables high, data not a copy of anything
  initial
  begin
    rx_enb_n = 1'b1;
    rx_addr  = 2'h0;
    tx_enb_n = 1'b1;
    tx_addr  = 2'h0;
    tx_soc   = 1'b0;
    tx_data  = 8'h5a;
    tx_prty  = 1'b0;
    hang     = 1'b0;
    lat      = 8'h0;
  end

  // One link cycle, signals move just after the rise
  task automatic lcyc(input bit tx);
    if (tx)
      @(posedge tx_clk);
    else
      @(posedge rx_clk);
    @(negedge clk);
  endtask

  // Enable held low on a port without a cell, to be refused
  task automatic rx_poke(input logic [1:0] p);
    lcyc(1'b0);
    rx_addr = p;
    lcyc(1'b0);
    rx_enb_n = 1'b0;
    repeat (6) lcyc(1'b0);
    rx_enb_n = 1'b1;
  endtask

  // Wait for cell-available, select, chain n cells, stop in time
  task automatic rx_sel(input logic [1:0] p, input int n);
    int k;
    k = 0;
    while (rx_clav[p] !== 1'b1 && k < 400)
    begin
      lcyc(1'b0);
      k++;
    end
    lcyc(1'b0);
    rx_addr = p;
    lcyc(1'b0);
    rx_enb_n = 1'b0;
    rx_addr  = ~p; // Selection must already be latched
    for (int c = 0; c < n; c++)
    begin
      k = 0;
      do
      begin
        @(posedge rx_clk);
        k++;
      end while (rx_soc !== 1'b1 && k < 200);
      if (c == 0)
        lat = 8'(k);
      hang = hang | (k >= 200);
    end
    repeat (CW - 3) @(posedge rx_clk);
    @(negedge clk);
    rx_enb_n = 1'b1;
  endtask

  // Address one cycle ahead, then the whole cell with enable low
  task automatic tx_cell(input logic [1:0] p, input logic [7:0] d [CW],
                         input logic [CW-1:0] sm, input logic [CW-1:0] bp,
                         input bit keep);
    // Enable still low means a chained cell: no new selection cycle
    if (tx_enb_n)
    begin
      lcyc(1'b1);
      tx_addr = p;
    end
    for (int i = 0; i < CW; i++)
    begin
      lcyc(1'b1);
      tx_enb_n = 1'b0;
      tx_soc   = sm[i];
      tx_data  = d[i];
      tx_prty  = (~^d[i]) ^ bp[i];
      tx_addr  = ~p; // Port must already be latched
    end
    if (!keep)
    begin
      lcyc(1'b1);
      tx_enb_n = 1'b1;
      tx_soc   = 1'b0;
      tx_data  = ~tx_data;
      tx_addr  = ~p;
    end
  endtask
endmodule // cbd_atm_model

// >>> tb/cell_bus_direct_status_flow_test.sv
// Purpose: Self-checking bench for the PHY-side cell bus flow control
// Assumes: Four ports, short cells, free-running link clocks
// Notes:   Drivers note expectations; monitors pop them as words appear
`timescale 1ns/1ps
module cell_bus_direct_status_flow_test;
  localparam int CW = 4;
  logic        clk = 1'b0;
  logic        rx_clk = 1'b0;
  logic        tx_clk = 1'b0;
  logic        rst_b, rx_enb_n, rx_prty, rx_soc, tx_enb_n, tx_soc, tx_prty;
  logic        urx_valid, urx_ready, utx_valid, utx_soc, tx_prty_err;
  logic        tx_len_err, hang;
  logic [1:0]  rx_addr, tx_addr, urx_port, utx_port, rx_port;
  logic [7:0]  rx_data, tx_data, urx_data, utx_data, lat;
  logic [3:0]  rx_clav, tx_clav, utx_room;
  logic [9:0]  rxq [$];
  logic [12:0] txq [$];
  logic [9:0]  ex;
  logic [31:0] seed = 32'h8e096c17;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          rx_left = 0;

  // Core clock and two link clocks of unrelated phase
  always #5 clk = ~clk;
  always #62.5 rx_clk = ~rx_clk;
  initial
  begin
    #21.3;
    forever #62.5 tx_clk = ~tx_clk;
  end

  cbd_phy_side #(.DATA_W(8), .CELL_WORDS(CW), .NPORT(4)) i_dut (
    .clk, .rst_b, .rx_clk, .rx_enb_n, .rx_addr, .rx_data, .rx_prty, .rx_soc,
    .rx_clav, .tx_clk, .tx_enb_n, .tx_addr, .tx_soc, .tx_data, .tx_prty,
    .tx_clav, .urx_valid, .urx_port, .urx_data, .urx_ready, .utx_valid,
    .utx_port, .utx_data, .utx_soc, .utx_room, .tx_prty_err, .tx_len_err
  );

  cbd_atm_model #(.CW(CW)) i_atm (
    .clk, .rx_clk, .tx_clk, .rx_soc, .rx_clav, .rx_enb_n, .rx_addr,
    .tx_enb_n, .tx_addr, .tx_soc, .tx_data, .tx_prty, .hang, .lat
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bounded wait until every noted result has been seen
  task automatic drain();
    int k;
    k = 0;
    while (rxq.size() + txq.size() != 0 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000 || hang === 1'b1)
    begin
      error_cnt++;
      conclude();
    end
  endtask

  // Load one cell into a port from the user stream
  task automatic put_cell(input logic [1:0] p, input logic clv);
    int k;
    logic [7:0] d;
    @(negedge clk);
    urx_port = p; // Port settles a cycle before the first word
    for (int i = 0; i < CW; i++)
    begin
      d = 8'(rnd());
      @(negedge clk);
      urx_valid = 1'b1;
      urx_port  = p;
      urx_data  = d;
      k = 0;
      while (urx_ready !== 1'b1 && k < 500)
      begin
        @(negedge clk);
        k++;
      end
      rxq.push_back({clv & (i == 0), i == 0, d});
    end
    @(negedge clk);
    urx_valid = 1'b0;
  endtask

  // Send one cell; SOC and bad-parity masks per word
  task automatic send(input logic [1:0] p, input logic [CW-1:0] sm,
                      input logic [CW-1:0] bp, input bit keep = 1'b0);
    logic [7:0] d [CW];
    for (int i = 0; i < CW; i++)
    begin
      d[i] = 8'(rnd());
      txq.push_back({p, sm[i], d[i], bp[i], sm[i] && i != 0});
    end
    i_atm.tx_cell(p, d, sm, bp, keep);
  endtask

  // Receive words matched to the oldest note, clav checked at SOC
  always @(posedge rx_clk)
    if (rst_b === 1'b1 && (rx_soc === 1'b1 || rx_left != 0))
    begin
      if (rxq.size() == 0)
        chk("rx unexpected", 16'h0, 16'h1);
      else
      begin
        ex = rxq.pop_front();
        chk("rx word", {ex[8:0], ~^ex[7:0]}, {rx_soc, rx_data, rx_prty});
        if (ex[8])
          chk("rx clav", ex[9], rx_clav[rx_port]);
      end
      rx_left = (rx_soc === 1'b1) ? CW - 1 : rx_left - 1;
    end

  // Transmit words handed on to the user side
  always @(posedge clk)
    if (utx_valid === 1'b1)
    begin
      if (txq.size() == 0)
        chk("tx unexpected", 16'h0, 16'h1);
      else
        chk("tx word", txq.pop_front(),
            {utx_port, utx_soc, utx_data, tx_prty_err, tx_len_err});
    end

  initial
  begin
    #400us;
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial
  begin
    rst_b     = 1'b0;
    urx_valid = 1'b0;
    urx_port  = 2'h0;
    urx_data  = 8'h0;
    utx_room  = 4'hf;
    rx_port   = 2'h0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (60) @(negedge clk);
    chk("tx clav", 16'hf, tx_clav);
    chk("rx clav idle", 16'h0, rx_clav);
    for (int p = 0; p < 4; p++)
      send(2'(p), 4'h1, 4'h0);
    fork
      send(2'h1, 4'h1, 4'h0);
      begin
        repeat (2) @(posedge tx_clk);
        @(negedge clk);
        utx_room = 4'h0;
      end
    join
    repeat (10) @(negedge clk);
    chk("tx clav hold", 16'hd, tx_clav);
    utx_room = 4'hf;
    send(2'h2, 4'h1, 4'h4);
    send(2'h3, 4'h1, 4'h0, 1'b1);
    send(2'h3, 4'h1, 4'h0);
    drain();
    i_atm.rx_poke(2'h3);
    repeat (60) @(negedge clk);
    for (int p = 0; p < 4; p++)
    begin
      rx_port = 2'(p);
      put_cell(rx_port, p == 2);
      if (p == 2)
      begin
        put_cell(rx_port, 1'b0);
        @(negedge clk);
        chk("urx ready full", 16'h0, urx_ready);
      end
      i_atm.rx_sel(rx_port, (p == 2) ? 2 : 1);
      chk("rx latency", 16'h3, lat);
      drain();
    end
    send(2'h0, 4'h5, 4'h0);
    drain();
    conclude();
  end
endmodule // cell_bus_direct_status_flow_test
